// ---- hw/uep_ctrl.sv ----
/*
  Host-side controller for a 32K x 8 UV/OTP parallel EPROM: read, identity
  read and pulse-and-verify byte programming through the part's pins.
  Assumes board drivers turn vcc_hi_o, vpp_hi_o and id_hv_o into the supply
  and high-voltage levels, and that byte_lines are resolved outside.
*/
// Functional notes
// - gate may fall up to select minus gate delay after select falls
// - elevated supply, gate high, select pulsed low with stable inputs writes
// - programmer presents location on address lines and byte on data lines
// - each write pulse lasts 95 to 105 us, nominally 100 us
// - pulse, verify, stop on match, give up after ten pulses; the code also stops at once when a wanted one reads back zero
// - elevated supply, select high, gate low returns the stored byte
// - parallel parts share pins but each has its own select line
// - identity line elevated with select, gate low, normal supply gives codes
// - main supply on no later and off no earlier than programming supply
`default_nettype none
module uep_ctrl
  import uep_pkg::*;
#(
  parameter int unsigned PW_CYC_P = PW_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  // response port
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic rsp_fail_o,
  output logic [3:0] rsp_pulses_o,
  // memory pins
  output logic [ADDR_W-1:0] addr_o,
  output logic ce_b_o,
  output logic oe_b_o,
  output logic vcc_hi_o,
  output logic vpp_hi_o,
  output logic id_hv_o,
  input wire logic [DATA_W-1:0] byte_lines_i,
  output logic [DATA_W-1:0] byte_lines_o,
  output logic byte_lines_oe_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_RD_WAIT, S_RD_END, S_PW_VCC, S_PW_VPP, S_PULSE, S_HOLD, S_OES,
    S_VFY, S_VFY_END, S_REDRIVE, S_PD_VPP, S_PD_VCC, S_DONE
  } uep_st_e;

  uep_st_e state_r;
  uep_st_e state_nxt;
  logic [1:0] op_r;
  logic [DATA_W-1:0] want_r;
  logic [DATA_W-1:0] rd_r;
  logic [DATA_W-1:0] bl_m_r;
  logic [DATA_W-1:0] bl_s_r;
  logic [3:0] pulses_r;
  logic fail_r;
  logic ce_b_nxt;
  logic oe_b_nxt;
  logic vcc_nxt;
  logic vpp_nxt;
  logic idhv_nxt;
  logic doe_nxt;
  logic accept;
  logic pass_w;
  logic bad_w;
  logic give_up;
  logic [1:0] op_now;

  uep_tmr_if #(.W(TMR_W)) tmr ();

  // cycle count minus one for each timed state
  function automatic logic [TMR_W-1:0] wait_of(input uep_st_e s);
    logic [TMR_W-1:0] n;
    n = TMR_W'(1);
    case (s)
      S_RD_WAIT: n = READ_CYC;
      S_RD_END, S_VFY_END: n = FLOAT_CYC;
      S_PULSE: n = TMR_W'(PW_CYC_P);
      S_VFY: n = GATE_CYC;
      S_PW_VCC, S_PW_VPP, S_HOLD, S_OES, S_REDRIVE, S_PD_VPP, S_PD_VCC: n = SETUP_CYC;
      default: n = TMR_W'(1);
    endcase
    return n - TMR_W'(1);
  endfunction

  uep_timer #(.W(TMR_W)) u_tmr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .t(tmr.tmr)
  );

  // timer restarts whenever the sequencer changes state
  assign tmr.start = (state_nxt != state_r);
  assign tmr.load = wait_of(state_nxt);

  // handshake and verify decode
  assign accept = cmd_valid_i && (state_r == S_IDLE);
  assign op_now = accept ? cmd_op_i : op_r; // op of the command being taken this cycle, else of the command in progress
  assign cmd_ready_o = (state_r == S_IDLE);
  assign rsp_valid_o = (state_r == S_DONE);
  assign pass_w = (rd_r == want_r);
  assign bad_w = |(want_r & ~rd_r); // a zero cell cannot return to one
  assign give_up = pass_w || bad_w || (pulses_r == MAX_PULSES);

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (accept) begin
          state_nxt = (cmd_op_i == OP_PROG) ? S_PW_VCC : S_RD_WAIT;
        end
      end
      S_RD_WAIT: if (tmr.done) state_nxt = S_RD_END;
      S_RD_END: if (tmr.done) state_nxt = S_DONE;
      S_PW_VCC: if (tmr.done) state_nxt = S_PW_VPP;
      S_PW_VPP: if (tmr.done) state_nxt = S_PULSE;
      S_PULSE: if (tmr.done) state_nxt = S_HOLD;
      S_HOLD: if (tmr.done) state_nxt = S_OES;
      S_OES: if (tmr.done) state_nxt = S_VFY;
      S_VFY: if (tmr.done) state_nxt = S_VFY_END;
      S_VFY_END: if (tmr.done) state_nxt = give_up ? S_PD_VPP : S_REDRIVE;
      S_REDRIVE: if (tmr.done) state_nxt = S_PULSE;
      S_PD_VPP: if (tmr.done) state_nxt = S_PD_VCC;
      S_PD_VCC: if (tmr.done) state_nxt = S_DONE;
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // pin levels decoded from the next state
  assign ce_b_nxt = !((state_nxt == S_RD_WAIT) || (state_nxt == S_PULSE));
  assign oe_b_nxt = !((state_nxt == S_RD_WAIT) || (state_nxt == S_VFY));
  assign vpp_nxt = (state_nxt == S_PW_VPP) || (state_nxt == S_PULSE) ||
                   (state_nxt == S_HOLD) || (state_nxt == S_OES) ||
                   (state_nxt == S_VFY) || (state_nxt == S_VFY_END) ||
                   (state_nxt == S_REDRIVE);
  assign vcc_nxt = vpp_nxt || (state_nxt == S_PW_VCC) || (state_nxt == S_PD_VPP);
  assign idhv_nxt = ((state_nxt == S_RD_WAIT) || (state_nxt == S_RD_END)) &&
                    (op_now == OP_IDENT);
  assign doe_nxt = (state_nxt == S_PW_VPP) || (state_nxt == S_PULSE) ||
                   (state_nxt == S_HOLD) || (state_nxt == S_REDRIVE);

  // sequencer state and registered pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= S_IDLE;
      ce_b_o <= 1'b1;
      oe_b_o <= 1'b1;
      vcc_hi_o <= 1'b0;
      vpp_hi_o <= 1'b0;
      id_hv_o <= 1'b0;
      byte_lines_oe_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ce_b_o <= ce_b_nxt; // this port is the one part's own select line
      oe_b_o <= oe_b_nxt;
      vcc_hi_o <= vcc_nxt;
      vpp_hi_o <= vpp_nxt;
      id_hv_o <= idhv_nxt;
      byte_lines_oe_o <= doe_nxt;
    end
  end

  // command capture; identity keeps only the lowest address line
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_r <= OP_READ;
      addr_o <= '0;
      want_r <= '1;
    end else if (accept) begin
      op_r <= cmd_op_i;
      addr_o <= (cmd_op_i == OP_IDENT) ? {{(ADDR_W-1){1'b0}}, cmd_addr_i[0]} : cmd_addr_i;
      want_r <= cmd_data_i;
    end
  end
  assign byte_lines_o = want_r;

  // two-flop synchroniser for the data lines
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bl_m_r <= '0;
      bl_s_r <= '0;
    end else begin
      bl_m_r <= byte_lines_i;
      bl_s_r <= bl_m_r;
    end
  end

  // sample at the end of the access window
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_r <= '0;
    end else if (tmr.done && ((state_r == S_RD_WAIT) || (state_r == S_VFY))) begin
      rd_r <= bl_s_r;
    end
  end

  // pulse count and result
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulses_r <= 4'h0;
      fail_r <= 1'b0;
    end else if (accept) begin
      pulses_r <= 4'h0;
      fail_r <= 1'b0;
    end else begin
      if ((state_nxt == S_PULSE) && (state_r != S_PULSE)) begin
        pulses_r <= pulses_r + 4'h1;
      end
      if ((state_r == S_VFY_END) && tmr.done) begin
        fail_r <= !pass_w;
      end
    end
  end
  assign rsp_data_o = rd_r;
  assign rsp_fail_o = fail_r;
  assign rsp_pulses_o = pulses_r;

  // helper: length of the current select-low stretch
  logic [TMR_W-1:0] lo_cnt_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lo_cnt_r <= '0;
    end else begin
      lo_cnt_r <= ce_b_o ? '0 : lo_cnt_r + TMR_W'(1);
    end
  end

  sequence s_gate_held;
    !oe_b_o [*8];
  endsequence
  sequence s_inhibit_after;
    (ce_b_o && vpp_hi_o) [*2];
  endsequence

  a_pulse_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(ce_b_o) && vpp_hi_o |-> lo_cnt_r == TMR_W'(PW_CYC_P))
    else $error("write pulse length wrong");
  a_prog_gate_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vpp_hi_o && !ce_b_o |-> oe_b_o && byte_lines_oe_o)
    else $error("gate or data not set during write pulse");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ce_b_o && vpp_hi_o |-> $stable(addr_o) && $stable(byte_lines_o))
    else $error("address or data moved during write pulse");
  a_pulse_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(ce_b_o) && vpp_hi_o |-> pulses_r <= MAX_PULSES ##1 s_inhibit_after)
    else $error("pulse loop overran or select did not return high");
  a_verify_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vpp_hi_o && !oe_b_o |-> ce_b_o && !byte_lines_oe_o)
    else $error("verify with select low or data driven");
  a_supply_order: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vpp_hi_o |-> vcc_hi_o && $past(vcc_hi_o))
    else $error("programming supply without main supply");
  a_ident_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    id_hv_o && !oe_b_o |-> !ce_b_o && !vpp_hi_o && !byte_lines_oe_o)
    else $error("identity read with wrong pin levels");
  a_read_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(oe_b_o) && !vpp_hi_o |-> s_gate_held)
    else $error("gate released before data valid");
  a_gate_with_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(ce_b_o) && !vpp_hi_o |-> $fell(oe_b_o))
    else $error("gate late after select in read");
  a_ident_with_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(ce_b_o) && !vpp_hi_o && (op_r == OP_IDENT) |-> id_hv_o)
    else $error("identity line not raised with select");
endmodule
`default_nettype wire

// ---- hw/uep_pkg.sv ----
/*
  Shared constants for the EPROM programmer controller: widths, command codes,
  pin timing figures in ns and the clock counts derived from them.
  Assumes a 200 MHz system clock.
*/
`default_nettype none
package uep_pkg;
  // geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TMR_W = 16;
  // clock and timing figures (ns)
  localparam int CLK_NS = 5;
  localparam int T_ACC_NS = 200; // address_access_delay
  localparam int T_CE_NS = 200; // select_access_delay
  localparam int T_OE_NS = 100; // gate_access_delay
  localparam int T_DF_NS = 130; // float delay in programming modes
  localparam int T_SETUP_NS = 2000; // supply, address, data, gate setup and hold
  localparam int T_PW_NS = 100000; // write_pulse_width nominal
  localparam int SYNC_CYC = 2;
  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  // derived counts (least times rounded up)
  // access waits add the synchroniser, the capture flop and one edge of margin,
  // so the pins are sampled strictly after the access time has run out
  localparam logic [TMR_W-1:0] READ_CYC =
    TMR_W'(cyc_up((T_ACC_NS > T_CE_NS) ? T_ACC_NS : T_CE_NS) + SYNC_CYC + 2);
  localparam logic [TMR_W-1:0] GATE_CYC = TMR_W'(cyc_up(T_OE_NS) + SYNC_CYC + 2);
  localparam logic [TMR_W-1:0] FLOAT_CYC = TMR_W'(cyc_up(T_DF_NS));
  localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'(cyc_up(T_SETUP_NS));
  localparam int PW_CYC = T_PW_NS / CLK_NS;
  // pulse loop limit
  localparam logic [3:0] MAX_PULSES = 4'hA;
  // command codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_IDENT = 2'h1;
  localparam logic [1:0] OP_PROG = 2'h2;
endpackage
`default_nettype wire

// ---- hw/uep_tmr_if.sv ----
/*
  Carrier between the controller sequencer and its delay timer.
  Assumes both ends share one clock.
*/
`default_nettype none
interface uep_tmr_if #(parameter int W = 16);
  logic start;
  logic [W-1:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// ---- hw/uep_timer.sv ----
/*
  Down-counting delay timer: a start pulse loads a count, done rises when it
  has run out. Assumes load is the wanted cycle count minus one.
*/
`default_nettype none
module uep_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // sequencer side
  uep_tmr_if.tmr t
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // reload on start, otherwise count down to zero
  assign cnt_nxt = t.start ? t.load : ((cnt_r == '0) ? cnt_r : cnt_r - W'(1));
  // done must not look at start: start is decoded from done, which would close a loop
  assign t.done = (cnt_r == '0);

  // counter register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- bench/uep_mem_model.sv ----
/*
  Pin-level model of the 32K x 8 EPROM facing the controller.
  Assumes the bench resolves the shared byte lines from both drivers.
*/
`default_nettype none
module uep_mem_model
  import uep_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'hC3 // arbitrary value
) (
  // pins from the controller
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic ce_b_i,
  input wire logic oe_b_i,
  input wire logic vcc_hi_i,
  input wire logic vpp_hi_i,
  input wire logic id_hv_i,
  input wire logic [DATA_W-1:0] din_i,
  // pulses a cell takes before its zeros stick
  input wire logic [3:0] need_i,
  // data drive and supply order flag
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic seq_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [3:0] hits [2**ADDR_W];
  realtime t_sel;
  realtime t_gate;
  realtime t_adr;
  logic ok_r;
  // mode decode; anything else floats, and only a program pulse writes
  wire rd_w = !vpp_hi_i && !ce_b_i && !oe_b_i && !id_hv_i;
  wire id_w = !vpp_hi_i && !ce_b_i && !oe_b_i && id_hv_i;
  wire vf_w = vpp_hi_i && ce_b_i && !oe_b_i;
  wire [DATA_W-1:0] data_w = id_w ? (addr_i[0] ? TYPE_CODE : MAKER_CODE) : mem[addr_i];
  assign dq_oe_o = rd_w || id_w || vf_w;
  assign dq_o = ok_r ? data_w : ~data_w; // wrong data until access time runs out
  // erased array, no flags at start
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'hFF;
      hits[i] = 4'h0;
    end
    seq_err_o = 1'b0;
    t_sel = 0;
    t_gate = 0;
    t_adr = 0;
  end
  // access timing stamps
  always @(negedge ce_b_i) t_sel = $realtime;
  always @(negedge oe_b_i) t_gate = $realtime;
  always @(addr_i) t_adr = $realtime;
  always #1 ok_r = (vf_w || $realtime >= t_sel + T_CE_NS) && $realtime >= t_adr + T_ACC_NS
    && $realtime >= t_gate + T_OE_NS;
  // write at the end of a select pulse under programming supply
  always @(posedge ce_b_i) begin
    if (vcc_hi_i && vpp_hi_i && oe_b_i) begin
      hits[addr_i] = hits[addr_i] + 4'h1;
      if (hits[addr_i] >= need_i) mem[addr_i] = mem[addr_i] & din_i;
    end
  end
  // programming supply must never stand without main supply
  always @(posedge vpp_hi_i or negedge vcc_hi_i) begin
    if (vpp_hi_i && !vcc_hi_i) seq_err_o = 1'b1;
  end
endmodule
`default_nettype wire

// ---- bench/uv_eprom_mode_and_program_control_test.sv ----
/*
  Self-checking bench for the EPROM controller against the pin model.
  Assumes package constants; the write pulse is cut to 50 cycles.
*/
`default_nettype none
module uv_eprom_mode_and_program_control_test
  import uep_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 50;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] TY = 8'hC3;
  typedef struct packed {
    logic [1:0] op;
    logic [14:0] addr;
    logic [7:0] data;
    logic [3:0] need;
    logic [7:0] xd;
    logic xf;
    logic [3:0] xp;
  } uep_row_s;
  logic clk, rst_b, cmd_valid, cmd_ready, rsp_valid, rsp_fail, ce_b, oe_b;
  logic vcc_hi, vpp_hi, id_hv, c_oe, m_oe, seq_err;
  logic [1:0] cmd_op;
  logic [3:0] need, rsp_pulses;
  logic [14:0] cmd_addr, addr;
  logic [7:0] cmd_data, rsp_data, c_dq, m_dq, bus, last;
  int err_total, num_checks, pw_cnt;
  uep_row_s rows [8] = '{
    '{OP_READ, 15'h0000, 8'h00, 4'h1, 8'hFF, 1'b0, 4'h0},
    '{OP_PROG, 15'h0001, 8'hA5, 4'h1, 8'hA5, 1'b0, 4'h1},
    '{OP_READ, 15'h0001, 8'h00, 4'h1, 8'hA5, 1'b0, 4'h0},
    '{OP_IDENT, 15'h0000, 8'h00, 4'h1, MK, 1'b0, 4'h0},
    '{OP_IDENT, 15'h0001, 8'h00, 4'h1, TY, 1'b0, 4'h0},
    '{2'h3, 15'h0001, 8'h00, 4'h1, 8'hA5, 1'b0, 4'h0},
    '{OP_PROG, 15'h7FFF, 8'h00, 4'h1, 8'h00, 1'b0, 4'h1},
    '{OP_READ, 15'h7FFF, 8'h00, 4'h1, 8'h00, 1'b0, 4'h0}};
  // released byte lines toggle every cycle out of reset, and hold at FF during reset
  assign bus = c_oe ? c_dq : (m_oe ? m_dq : ~last);
  always @(posedge clk) last <= rst_b ? bus : 8'h00;
  uep_ctrl #(.PW_CYC_P(PW)) u_uep_ctrl (.clk_i(clk), .rst_b_i(rst_b), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_fail_o(rsp_fail),
    .rsp_pulses_o(rsp_pulses), .addr_o(addr), .ce_b_o(ce_b), .oe_b_o(oe_b), .vcc_hi_o(vcc_hi),
    .vpp_hi_o(vpp_hi), .id_hv_o(id_hv), .byte_lines_i(bus), .byte_lines_o(c_dq),
    .byte_lines_oe_o(c_oe));
  uep_mem_model #(.MAKER_CODE(MK), .TYPE_CODE(TY)) u_uep_mem_model (.addr_i(addr),
    .ce_b_i(ce_b), .oe_b_i(oe_b), .vcc_hi_i(vcc_hi), .vpp_hi_i(vpp_hi), .id_hv_i(id_hv),
    .din_i(bus), .need_i(need), .dq_o(m_dq), .dq_oe_o(m_oe), .seq_err_o(seq_err));
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // present one command and see it taken
  task automatic issue(input uep_row_s r);
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = r.op;
    cmd_addr = r.addr;
    cmd_data = r.data;
    need = r.need;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic run(input uep_row_s r);
    int lat;
    lat = 0;
    issue(r);
    while (rsp_valid !== 1'b1 && lat < 30000) begin
      @(posedge clk);
      #1 lat++;
    end
    chk(rsp_valid, 1'b1);
    chk(rsp_data, r.xd);
    chk(rsp_fail, r.xf);
    if (r.xp != 4'hF) chk(rsp_pulses, r.xp);
    if (r.op != OP_PROG) chk(lat >= 69 && lat <= 70, 1'b1);
  endtask
  // pin idle pattern
  task automatic idle_chk;
    chk({ce_b, oe_b, vcc_hi, vpp_hi, id_hv, c_oe, cmd_ready, rsp_valid}, 8'hC2);
  endtask
  // pulse width, drive conflict and program gate watch
  always @(negedge clk) begin
    if (c_oe && m_oe) chk({c_oe, m_oe}, 2'h0);
    if (vpp_hi && !ce_b && !oe_b) chk(oe_b, 1'b1);
    if (!rst_b) pw_cnt = 0;
    else if (vpp_hi && !ce_b) pw_cnt++;
    else if (pw_cnt != 0) begin
      chk(pw_cnt, PW);
      pw_cnt = 0;
    end
  end
  // watchdog: about twice the expected run of some 30k cycles
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    pw_cnt = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 15'h0000;
    cmd_data = 8'h00;
    need = 4'h1;
    repeat (3) @(negedge clk);
    idle_chk();
    rst_b = 1'b1;
    foreach (rows[i]) run(rows[i]);
    run('{OP_PROG, 15'h0002, 8'h3C, 4'h3, 8'h3C, 1'b0, 4'h3});
    run('{OP_PROG, 15'h0003, 8'h0F, 4'hF, 8'hFF, 1'b1, MAX_PULSES});
    run('{OP_PROG, 15'h0001, 8'hFF, 4'h1, 8'hA5, 1'b1, 4'hF});
    run('{OP_READ, 15'h0003, 8'h00, 4'h1, 8'hFF, 1'b0, 4'h0});
    issue('{OP_PROG, 15'h0004, 8'h00, 4'h1, 8'h00, 1'b0, 4'h0});
    repeat (100) @(negedge clk);
    rst_b = 1'b0;
    #1 idle_chk();
    @(negedge clk);
    rst_b = 1'b1;
    run('{OP_READ, 15'h0004, 8'h00, 4'h1, 8'hFF, 1'b0, 4'h0});
    chk(seq_err, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
